// file: sfp_pkg.sv
// How it works
// - Program page is 256 or 512 bytes, selected by a config register bit.
// - Pages align to page size; one program changes one byte up to a page.
// - A program command with a single data byte works at any address.
// - Programming only clears bits; the array ANDs data into stored bytes.
// - Program and erase need the write enable latch, set by write enable.
// - 02h takes 3 or 4 address bytes by config; 12h always 4; data follows.
// - Load pointer wraps to byte zero of the same page; later bytes overwrite.
// - Bytes not loaded in the page are left unchanged.
// - Write-in-progress, status bit 0, reads 1 while programming runs.
// - Program error flag, status bit 6, sets when programming a protected area.
// - In quad mode the opcode uses four lines, two clocks per byte.
// - Small wipe commands are ignored when the uniform layout bit is 1.
// - Small wipe sets every byte of the addressed 4-kB sector to FFh.
// - 20h takes 3 or 4 address bytes by config; 21h always takes 4.
// - Erase starts only if chip select rises right after the last address bit.
// - Write-in-progress reads 1 during erase and 0 once it finishes.
// - Small wipe on a protected sector does not run and sets the erase error.
// - Small wipe outside the parameter sectors does not run, no error set.
// - D8h takes 3 or 4 address bytes by config, DCh 4; sector becomes FFh.
// - Uniform wipe on a protected sector does not run and sets erase error.
// - A config bit selects 64 kB or 256 kB for the uniform wipe.
// - Uniform wipe skips the overlaid parameter 32 kB when parameter sectors exist.
// - A 256-kB range holding any protected sector erases nothing, sets error.
package sfp_pkg;
	localparam int ADDR_W = 24;
	localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] OPC_PAGE_PROGRAM_CMD = 8'h02;
	localparam logic [7:0] OPC_PAGE_PROGRAM_4BYTE_CMD = 8'h12;
	localparam logic [7:0] OPC_SMALL_WIPE_CMD = 8'h20;
	localparam logic [7:0] OPC_SMALL_WIPE_4BYTE_CMD = 8'h21;
	localparam logic [7:0] OPC_UNIFORM_WIPE_CMD = 8'hD8;
	localparam logic [7:0] OPC_UNIFORM_WIPE_4BYTE_CMD = 8'hDC;
	localparam logic [7:0] OFS_STATUS_REG1_VOLATILE = 8'h00;
	localparam logic [7:0] OFS_CONFIG_REG2_VOLATILE = 8'h04;
	localparam logic [7:0] OFS_CONFIG_REG3_VOLATILE = 8'h08;
	localparam logic [7:0] OFS_DYNAMIC_PROTECT_BIT = 8'h0C;
	localparam int ST_INPROG = 0;
	localparam int ST_WEN = 1;
	localparam int ST_BLK = 2;
	localparam int ST_EERR = 5;
	localparam int ST_PERR = 6;
	localparam int CF2_QUAD = 6;
	localparam int CF2_ADDR4 = 7;
	localparam int CF3_WIPE256 = 1;
	localparam int CF3_TOPPAR = 2;
	localparam int CF3_UNIFORM = 3;
	localparam int CF3_PAGE512 = 4;
	localparam logic [2:0] BLK_RESET = 3'h0;
	localparam logic [31:0] DYN_RESET = 32'h0000_0000;
	localparam logic [18:0] SZ_4K = 19'h01000;
	localparam logic [18:0] SZ_32K = 19'h08000;
	localparam logic [18:0] SZ_64K = 19'h10000;
	localparam logic [18:0] SZ_256K = 19'h40000;
	localparam logic [ADDR_W-1:0] PAR_BOT_END = 24'h008000;
	localparam logic [ADDR_W-1:0] PAR_TOP_BASE = 24'hFF8000;
	localparam logic [ADDR_W-1:0] ARRAY_LAST = 24'hFFFFFF;
	localparam int CLK_MHZ = 100;
	localparam int PGM_TIME_NS = 2000;
	localparam int SMALL_TIME_NS = 5000;
	localparam int UNI_TIME_NS = 20000;
	localparam logic [11:0] PGM_CYC = 12'((PGM_TIME_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] SMALL_CYC = 12'((SMALL_TIME_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] UNI_CYC = 12'((UNI_TIME_NS * CLK_MHZ + 999) / 1000);
	typedef enum logic [2:0] {
		F_IDLE = 3'b000, F_OPC = 3'b001, F_ADDR = 3'b010,
		F_ADONE = 3'b011, F_DATA = 3'b100, F_SKIP = 3'b101
	} sfp_frame_t;
	typedef enum logic [1:0] {O_IDLE = 2'b00, O_PGM = 2'b01, O_WIPE = 2'b10, O_WAIT = 2'b11} sfp_op_t;
	typedef enum logic [1:0] {K_NONE = 2'b00, K_PGM = 2'b01, K_SMALL = 2'b10, K_UNI = 2'b11} sfp_kind_t;
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic [3:0] io;
	} sfp_pins_t;
	localparam sfp_pins_t PINS_IDLE = 6'h10;
	typedef struct packed {
		logic pgm;
		logic wipe;
		logic [ADDR_W-1:0] addr;
		logic [18:0] len;
		logic [7:0] data;
	} sfp_arr_t;
endpackage

// file: sfp_flash_cmd.sv
`timescale 1ns/1ps
`default_nettype none
module sfp_flash_cmd
	import sfp_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire sfp_pins_t SPI_I,
	output var sfp_arr_t ARR_O
);
	// Opcode classes
	function automatic sfp_kind_t kind_of(input logic [7:0] opc);
		case (opc)
			OPC_PAGE_PROGRAM_CMD, OPC_PAGE_PROGRAM_4BYTE_CMD: kind_of = K_PGM;
			OPC_SMALL_WIPE_CMD, OPC_SMALL_WIPE_4BYTE_CMD: kind_of = K_SMALL;
			OPC_UNIFORM_WIPE_CMD, OPC_UNIFORM_WIPE_4BYTE_CMD: kind_of = K_UNI;
			default: kind_of = K_NONE;
		endcase
	endfunction

	// The 4-byte opcodes ignore the address-length bit
	function automatic logic wide_addr(input logic [7:0] opc, input logic cfg4);
		wide_addr = cfg4 | (opc == OPC_PAGE_PROGRAM_4BYTE_CMD) | (opc == OPC_SMALL_WIPE_4BYTE_CMD)
			| (opc == OPC_UNIFORM_WIPE_4BYTE_CMD);
	endfunction

	// Nonzero block bits n lock the top 2^(n+1) 64-kB sectors, zero locks none; dynamic bits lock 512-kB regions
	function automatic logic is_locked(input logic [ADDR_W-1:0] a, input logic [2:0] blk,
		input logic [31:0] dyn);
		logic [8:0] cnt;
		cnt = 9'h001 << ({1'b0, blk} + 4'h1);
		is_locked = ((blk != 3'h0) && ({1'b0, a[23:16]} >= (9'h100 - cnt))) || dyn[a[23:19]];
	endfunction

	sfp_pins_t s1_q, s2_q, s3_q;
	logic write_enable_latch_q, perr_q, eerr_q;
	logic addr4_q, quad_instr_mode_q, page512_q, uniform_q, toppar_q, wipe256_q;
	logic [2:0] block_protect_bits_q;
	logic [31:0] dynamic_protect_bit_q;
	logic [7:0] sh_q;
	logic [2:0] bcnt_q;
	sfp_frame_t frame_q, frame_d;
	logic [7:0] opc_q;
	logic [31:0] addr_q;
	logic [2:0] left_q;
	logic [8:0] ptr_q;
	logic got_q;
	logic [7:0] pbuf_q [0:511];
	logic [511:0] pval_q;
	sfp_op_t op_q;
	logic [8:0] idx_q;
	logic [11:0] tmr_q;
	logic [ADDR_W-1:0] obase_q;
	logic [18:0] olen_q;
	sfp_arr_t arr_q;

	// Two-flop synchroniser on every pin; s3 exists only for edge detection
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			s1_q <= PINS_IDLE;
			s2_q <= PINS_IDLE;
			s3_q <= PINS_IDLE;
		end else begin
			s1_q <= SPI_I;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Link edges seen on the local clock
	wire logic sck_rise = s2_q.sck & ~s3_q.sck;
	wire logic cs_fall = s3_q.cs_n & ~s2_q.cs_n;
	wire logic cs_rise = s2_q.cs_n & ~s3_q.cs_n;
	wire logic take = sck_rise & ~s2_q.cs_n;
	wire logic busy = (op_q != O_IDLE);

	// Quad mode takes a nibble per edge, so a byte closes after two edges
	wire logic [7:0] sh_d = quad_instr_mode_q ? {sh_q[3:0], s2_q.io} : {sh_q[6:0], s2_q.io[0]};
	wire logic byte_done = quad_instr_mode_q ? bcnt_q[2] : (bcnt_q == 3'h7);
	wire logic [2:0] bstep = quad_instr_mode_q ? 3'h4 : 3'h1;

	// Bit assembly restarts with each frame
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			sh_q <= 8'h00;
			bcnt_q <= 3'h0;
		end else if (cs_fall) begin
			bcnt_q <= 3'h0;
		end else if (take) begin
			sh_q <= sh_d;
			bcnt_q <= bcnt_q + bstep;
		end
	end

	// Frame decode
	wire sfp_kind_t kind_new = kind_of(sh_d);
	wire sfp_kind_t kind_q = kind_of(opc_q);
	wire logic [31:0] addr_d = {addr_q[23:0], sh_d};
	wire logic [8:0] ptr_start = page512_q ? addr_d[8:0] : {1'b0, addr_d[7:0]};
	wire logic [8:0] ptr_next = page512_q ? ptr_q + 9'h001 : {1'b0, ptr_q[7:0] + 8'h01};
	wire logic load = take && byte_done && (frame_q == F_DATA);
	wire logic pclr = take && byte_done && (frame_q == F_OPC) && (kind_new == K_PGM) && !busy;

	// Any clock edge after the last address bit spoils an erase frame
	always_comb begin
		frame_d = frame_q;
		if (cs_rise) begin
			frame_d = F_IDLE;
		end else if (cs_fall) begin
			frame_d = F_OPC;
		end else if (take) begin
			case (frame_q)
				F_OPC: begin
					if (byte_done) begin
						if (busy) frame_d = F_SKIP;
						else if (sh_d == OPC_WRITE_ENABLE_CMD) frame_d = F_ADONE;
						else if (kind_new != K_NONE) frame_d = F_ADDR;
						else frame_d = F_SKIP;
					end
				end
				F_ADDR: begin
					if (byte_done && left_q == 3'h1) begin
						frame_d = (kind_q == K_PGM) ? F_DATA : F_ADONE;
					end
				end
				F_ADONE: frame_d = F_SKIP;
				default: frame_d = frame_q;
			endcase
		end
	end

	// Opcode, address and load pointer
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			frame_q <= F_IDLE;
			opc_q <= 8'h00;
			addr_q <= 32'h0000_0000;
			left_q <= 3'h0;
			ptr_q <= 9'h000;
			got_q <= 1'b0;
		end else begin
			frame_q <= frame_d;
			if (cs_fall) opc_q <= 8'h00;
			if (take && byte_done && frame_q == F_OPC) begin
				opc_q <= sh_d;
				addr_q <= 32'h0000_0000;
				left_q <= wide_addr(sh_d, addr4_q) ? 3'h4 : 3'h3;
				got_q <= 1'b0;
			end
			if (take && byte_done && frame_q == F_ADDR) begin
				addr_q <= addr_d;
				left_q <= left_q - 3'h1;
				ptr_q <= ptr_start;
			end
			if (load) begin
				ptr_q <= ptr_next;
				got_q <= 1'b1;
			end
		end
	end

	// Page buffer is storage only, so it carries no reset
	always_ff @(posedge CLK_I) begin
		if (load) pbuf_q[ptr_q] <= sh_d;
	end

	// Valid map: only loaded bytes reach the array
	always_ff @(posedge CLK_I) begin
		if (RESET_I) pval_q <= '0;
		else if (pclr) pval_q <= '0;
		else if (load) pval_q[ptr_q] <= 1'b1;
	end

	// Geometry of the addressed page and sectors
	wire logic [ADDR_W-1:0] a = addr_q[ADDR_W-1:0];
	wire logic [ADDR_W-1:0] page_base = page512_q ? {a[23:9], 9'h000} : {a[23:8], 8'h00};
	wire logic [ADDR_W-1:0] small_base = {a[23:12], 12'h000};
	wire logic [18:0] uni_len = wipe256_q ? SZ_256K : SZ_64K;
	wire logic [ADDR_W-1:0] uni_base = wipe256_q ? {a[23:18], 18'h00000} : {a[23:16], 16'h0000};
	wire logic [ADDR_W-1:0] uni_last = uni_base + 24'(uni_len - 19'h00001);
	wire logic cut_bot = !uniform_q && !toppar_q && (uni_base == 24'h000000);
	wire logic cut_top = !uniform_q && toppar_q && (uni_last == ARRAY_LAST);
	// Overlaid parameter area is cut out of the uniform range
	wire logic [ADDR_W-1:0] er_addr = cut_bot ? PAR_BOT_END : uni_base;
	wire logic [18:0] er_len = (cut_bot || cut_top) ? uni_len - SZ_32K : uni_len;
	wire logic in_par = toppar_q ? (a >= PAR_TOP_BASE) : (a < PAR_BOT_END);
	wire logic is_small = (kind_q == K_SMALL);

	// Protection lookups; a 256-kB range is locked if either end is locked
	wire logic lock_pgm = is_locked(page_base, block_protect_bits_q, dynamic_protect_bit_q);
	wire logic lock_small = is_locked(small_base, block_protect_bits_q, dynamic_protect_bit_q);
	wire logic lock_uni = is_locked(uni_base, block_protect_bits_q, dynamic_protect_bit_q)
		| is_locked(uni_last, block_protect_bits_q, dynamic_protect_bit_q);
	wire logic lock_sel = is_small ? lock_small : lock_uni;

	// Commit decode at the chip-select rise
	wire logic write_enable_cmd_go = cs_rise && (frame_q == F_ADONE) && (opc_q == OPC_WRITE_ENABLE_CMD);
	wire logic pgm_go = cs_rise && (frame_q == F_DATA) && got_q && (bcnt_q == 3'h0)
		&& (kind_q == K_PGM);
	wire logic wipe_go = cs_rise && (frame_q == F_ADONE) && (kind_q == K_SMALL || kind_q == K_UNI);
	wire logic broken = cs_rise && (kind_q != K_NONE) && !pgm_go && !wipe_go
		&& (frame_q == F_ADDR || frame_q == F_DATA || frame_q == F_SKIP);
	wire logic small_skip = wipe_go && is_small && uniform_q;
	wire logic small_big = wipe_go && is_small && !uniform_q && !in_par;
	wire logic wipe_ok = wipe_go && !small_skip && !small_big;
	// Without the latch a command falls through with no effect
	wire logic pgm_start = pgm_go && write_enable_latch_q && !lock_pgm;
	wire logic pgm_fail = pgm_go && write_enable_latch_q && lock_pgm;
	wire logic er_go = wipe_ok && write_enable_latch_q && !lock_sel;
	wire logic eerr_set = wipe_ok && write_enable_latch_q && lock_sel;
	wire logic op_end = (op_q == O_WAIT) && (tmr_q == 12'h000);
	wire logic wen_clr = op_end | broken | pgm_fail | eerr_set | small_big;
	wire logic [8:0] psize_last = page512_q ? 9'h1FF : 9'h0FF;

	// Internal operation sequencer; the timer runs alongside the page walk
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			op_q <= O_IDLE;
			idx_q <= 9'h000;
			tmr_q <= 12'h000;
			obase_q <= '0;
			olen_q <= 19'h00000;
		end else begin
			case (op_q)
				O_IDLE: begin
					if (pgm_start) begin
						op_q <= O_PGM;
						idx_q <= 9'h000;
						tmr_q <= PGM_CYC;
						obase_q <= page_base;
					end else if (er_go) begin
						op_q <= O_WIPE;
						tmr_q <= is_small ? SMALL_CYC : UNI_CYC;
						obase_q <= is_small ? small_base : er_addr;
						olen_q <= is_small ? SZ_4K : er_len;
					end
				end
				O_PGM: begin
					idx_q <= idx_q + 9'h001;
					if (tmr_q != 12'h000) tmr_q <= tmr_q - 12'h001;
					if (idx_q == psize_last) op_q <= O_WAIT;
				end
				O_WIPE: begin
					op_q <= O_WAIT;
					if (tmr_q != 12'h000) tmr_q <= tmr_q - 12'h001;
				end
				O_WAIT: begin
					if (tmr_q == 12'h000) op_q <= O_IDLE;
					else tmr_q <= tmr_q - 12'h001;
				end
				default: op_q <= O_IDLE;
			endcase
		end
	end

	// Array strobes; the array ANDs program data in, so bits only fall
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			arr_q <= '0;
		end else begin
			arr_q.pgm <= (op_q == O_PGM) && pval_q[idx_q];
			arr_q.wipe <= (op_q == O_WIPE);
			arr_q.addr <= (op_q == O_PGM) ? (obase_q | {15'h0000, idx_q}) : obase_q;
			arr_q.len <= olen_q;
			arr_q.data <= pbuf_q[idx_q];
		end
	end
	assign ARR_O = arr_q;

	// Status flags: hardware set wins over a software clear in the same cycle
	wire logic acc = PSEL_I & PENABLE_I;
	wire logic setup = PSEL_I & ~PENABLE_I;
	wire logic hit_st = (PADDR_I == OFS_STATUS_REG1_VOLATILE);
	wire logic hit_c2 = (PADDR_I == OFS_CONFIG_REG2_VOLATILE);
	wire logic hit_c3 = (PADDR_I == OFS_CONFIG_REG3_VOLATILE);
	wire logic hit_dy = (PADDR_I == OFS_DYNAMIC_PROTECT_BIT);
	wire logic hit = hit_st | hit_c2 | hit_c3 | hit_dy;
	wire logic wr = acc & PWRITE_I;
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			write_enable_latch_q <= 1'b0;
			perr_q <= 1'b0;
			eerr_q <= 1'b0;
		end else begin
			if (write_enable_cmd_go) write_enable_latch_q <= 1'b1;
			else if (wen_clr) write_enable_latch_q <= 1'b0;
			if (pgm_fail) perr_q <= 1'b1;
			else if (wr && hit_st && PWDATA_I[ST_PERR]) perr_q <= 1'b0;
			if (eerr_set) eerr_q <= 1'b1;
			else if (wr && hit_st && PWDATA_I[ST_EERR]) eerr_q <= 1'b0;
		end
	end

	// Configuration and protection registers
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			block_protect_bits_q <= BLK_RESET;
			dynamic_protect_bit_q <= DYN_RESET;
			{addr4_q, quad_instr_mode_q} <= 2'h0;
			{page512_q, uniform_q, toppar_q, wipe256_q} <= 4'h0;
		end else if (wr) begin
			if (hit_st) block_protect_bits_q <= PWDATA_I[ST_BLK+2:ST_BLK];
			if (hit_dy) dynamic_protect_bit_q <= PWDATA_I;
			if (hit_c2) {addr4_q, quad_instr_mode_q} <= {PWDATA_I[CF2_ADDR4], PWDATA_I[CF2_QUAD]};
			if (hit_c3) begin
				page512_q <= PWDATA_I[CF3_PAGE512];
				uniform_q <= PWDATA_I[CF3_UNIFORM];
				toppar_q <= PWDATA_I[CF3_TOPPAR];
				wipe256_q <= PWDATA_I[CF3_WIPE256];
			end
		end
	end

	// Read words; busy shows as write-in-progress
	wire logic [31:0] st_word = {25'h0, perr_q, eerr_q, block_protect_bits_q, write_enable_latch_q,
		busy};
	wire logic [31:0] c2_word = {24'h0, addr4_q, quad_instr_mode_q, 6'h00};
	wire logic [31:0] c3_word = {27'h0, page512_q, uniform_q, toppar_q, wipe256_q, 1'b0};
	wire logic [31:0] rd_mux = hit_st ? st_word : hit_c2 ? c2_word : hit_c3 ? c3_word
		: hit_dy ? dynamic_protect_bit_q : 32'h0000_0000;

	// Read data is captured in setup so the zero-wait access phase sees it
	always_ff @(posedge CLK_I) begin
		if (RESET_I) PRDATA_O <= 32'h0000_0000;
		else if (setup) PRDATA_O <= rd_mux;
	end
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = acc & ~hit;

	chk_wen_before_op: assert property (@(posedge CLK_I) disable iff (RESET_I)
		$rose(busy) |-> $past(write_enable_latch_q))
		else $error("operation began without write enable latch");
	chk_busy_program: assert property (@(posedge CLK_I) disable iff (RESET_I)
		pgm_start |=> st_word[ST_INPROG] [*8])
		else $error("write in progress low during program");
	chk_busy_erase: assert property (@(posedge CLK_I) disable iff (RESET_I)
		er_go |=> st_word[ST_INPROG] [*8])
		else $error("write in progress low during erase");
	// Status must drop in the cycle after the wait state finds the timer at zero, for either kind of operation
	chk_busy_clear: assert property (@(posedge CLK_I) disable iff (RESET_I)
		op_end |=> !st_word[ST_INPROG])
		else $error("write in progress stuck after operation");
	chk_page_bound: assert property (@(posedge CLK_I) disable iff (RESET_I)
		ARR_O.pgm |-> (ARR_O.addr[23:9] == obase_q[23:9]))
		else $error("program strobe left its page");
	chk_wrap_ptr: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(load && !page512_q && ptr_q == 9'h0FF) |=> (ptr_q == 9'h000))
		else $error("load pointer did not wrap in page");
	chk_small_ignore: assert property (@(posedge CLK_I) disable iff (RESET_I)
		small_skip |=> (op_q == O_IDLE) && (write_enable_latch_q == $past(write_enable_latch_q)))
		else $error("small wipe not ignored in uniform layout");
	chk_perr_lock: assert property (@(posedge CLK_I) disable iff (RESET_I)
		pgm_fail |=> perr_q && !busy && !write_enable_latch_q)
		else $error("protected program not flagged");
	chk_eerr_lock: assert property (@(posedge CLK_I) disable iff (RESET_I)
		eerr_set |=> eerr_q && (op_q == O_IDLE) [*2])
		else $error("protected erase ran or was not flagged");
	chk_big_noerr: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(small_big && !eerr_q) |=> !eerr_q && (op_q == O_IDLE))
		else $error("small wipe outside parameter area acted");
	chk_cs_commit: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(cs_rise && !busy && (kind_q == K_SMALL || kind_q == K_UNI) && frame_q != F_ADONE)
		|=> (op_q == O_IDLE) && !write_enable_latch_q)
		else $error("erase committed on early chip select");
	chk_wen_drop: assert property (@(posedge CLK_I) disable iff (RESET_I)
		$fell(busy) |-> !write_enable_latch_q)
		else $error("write enable latch kept after operation");
endmodule
`default_nettype wire

// file: sfp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model
	import sfp_pkg::*;
(
	input wire logic CLK_I,
	output var sfp_pins_t PINS_O
);
	logic [7:0] q[$];

	// Link clock rests low and select high outside frames
	initial PINS_O = PINS_IDLE;

	// Half of the 80 ns link period, counted in system clocks
	task automatic half();
		repeat (4) @(posedge CLK_I);
	endtask

	// Data is set up in the low phase so the rising edge finds it settled
	task automatic edge1(input logic [3:0] v);
		PINS_O.io <= v;
		half();
		PINS_O.sck <= 1'b1;
		half();
		PINS_O.sck <= 1'b0;
	endtask

	// Queued bytes go out MSB first; extra edges spoil an erase commit
	task automatic frame(input logic quad, input int extra);
		@(posedge CLK_I);
		PINS_O.cs_n <= 1'b0;
		foreach (q[k]) begin
			if (quad) begin
				edge1(q[k][7:4]);
				edge1(q[k][3:0]);
			end else begin
				for (int b = 7; b >= 0; b--) begin
					edge1({3'h0, q[k][b]});
				end
			end
		end
		repeat (extra) edge1(4'h0);
		half();
		PINS_O.cs_n <= 1'b1;
		PINS_O.io <= ~PINS_O.io; // Released lines must not hold the last value
		half();
		q.delete();
	endtask
endmodule
`default_nettype wire

// file: tb_spi_flash_program_erase_cmds.sv
`timescale 1ns/1ps
`default_nettype none
module tb_spi_flash_program_erase_cmds
	import sfp_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] padr = 8'h00;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd;
	logic prdy;
	logic perr;
	logic qm = 1'b0;
	sfp_pins_t pins;
	sfp_arr_t arr;
	logic [7:0] mem [logic [23:0]];
	logic [23:0] wadr;
	logic [18:0] wlen;
	int npgm;
	int nwipe;
	int checks = 0;
	int mismatches = 0;

	sfp_flash_cmd i_sfp_flash_cmd (
		.CLK_I(clk),
		.RESET_I(rst),
		.PSEL_I(psel),
		.PENABLE_I(pen),
		.PWRITE_I(pwr),
		.PADDR_I(padr),
		.PWDATA_I(pwd),
		.PRDATA_O(prd),
		.PREADY_O(prdy),
		.PSLVERR_O(perr),
		.SPI_I(pins),
		.ARR_O(arr)
	);
	sfp_host_model i_sfp_host_model (
		.CLK_I(clk),
		.PINS_O(pins)
	);

	always #5 clk = ~clk;

	// Array pulses are sampled mid-cycle, away from the launching edge
	always @(negedge clk) begin
		if (arr.pgm === 1'b1) begin
			npgm++;
			mem[arr.addr] = arr.data;
		end
		if (arr.wipe === 1'b1) begin
			nwipe++;
			wadr = arr.addr;
			wlen = arr.len;
		end
	end

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request is held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 50);
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 50) begin
			chk(32'h1, 32'h0);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
	endtask

	task automatic send(input logic [7:0] b[$], input int ex);
		npgm = 0;
		nwipe = 0;
		i_sfp_host_model.q = b;
		i_sfp_host_model.frame(qm, ex);
	endtask

	task automatic wen();
		send('{OPC_WRITE_ENABLE_CMD}, 0);
	endtask

	// Polls status; busy of x means the busy phase is not judged
	task automatic run(input logic busy);
		logic [31:0] s;
		logic e;
		int n;
		s = 32'h0;
		for (n = 0; n < 30 && s[ST_INPROG] !== 1'b1; n++) begin
			apb(1'b0, OFS_STATUS_REG1_VOLATILE, 32'h0, s, e);
		end
		if (busy !== 1'bx) begin
			chk(s[ST_INPROG], busy);
		end
		for (n = 0; n < 2000 && s[ST_INPROG] !== 1'b0; n++) begin
			apb(1'b0, OFS_STATUS_REG1_VOLATILE, 32'h0, s, e);
		end
		chk(s[ST_INPROG], 1'b0);
	endtask

	task automatic pgm(input logic [23:0] a, input logic [7:0] b[$], input logic busy);
		logic [7:0] f[$];
		f = {OPC_PAGE_PROGRAM_CMD, a[23:16], a[15:8], a[7:0]};
		f = {f, b};
		wen();
		send(f, 0);
		run(busy);
	endtask

	task automatic ers(input logic [7:0] op, input logic [31:0] c3, input logic [31:0] a,
		input int ex, input int nw, input logic [23:0] ea, input logic [18:0] el);
		wr(OFS_CONFIG_REG3_VOLATILE, c3);
		wen();
		if (op == OPC_SMALL_WIPE_4BYTE_CMD || op == OPC_UNIFORM_WIPE_4BYTE_CMD) begin
			send('{op, a[31:24], a[23:16], a[15:8], a[7:0]}, ex);
		end else begin
			send('{op, a[23:16], a[15:8], a[7:0]}, ex);
		end
		run(nw != 0);
		chk(nwipe, nw);
		if (nw != 0) begin
			chk(wadr, ea);
			chk(wlen, el);
		end
	endtask

	// Longest path is a few hundred microseconds; a millisecond means a hang
	initial begin
		#1000000;
		mismatches++;
		conclude();
	end

	initial begin
		logic [31:0] r;
		logic e;
		logic [7:0] blk16[$];
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		rd(OFS_STATUS_REG1_VOLATILE, 32'h0);
		apb(1'b0, 8'hF0, 32'h0, r, e);
		chk(e, 1'b1);
		// Program without the latch must leave the array alone
		send('{OPC_PAGE_PROGRAM_CMD, 8'h00, 8'h01, 8'h00, 8'h77}, 0);
		run(1'b0);
		chk(npgm, 0);
		wen();
		rd(OFS_STATUS_REG1_VOLATILE, 32'h2);
		send('{OPC_WRITE_ENABLE_CMD}, 0);
		pgm(24'h000104, '{8'hAA, 8'h55}, 1'b1);
		chk(npgm, 2);
		chk(mem[24'h000104], 8'hAA);
		chk(mem[24'h000105], 8'h55);
		rd(OFS_STATUS_REG1_VOLATILE, 32'h0);
		pgm(24'hABCDEF, '{8'h3C}, 1'b1);
		chk(mem[24'hABCDEF], 8'h3C);
		// Same start address wraps in a 256-byte page but not in a 512-byte page
		for (int m = 0; m < 2; m++) begin
			wr(OFS_CONFIG_REG3_VOLATILE, m ? 32'h10 : 32'h0);
			pgm(24'h0002FE, '{8'h11, 8'h22, 8'h33}, 1'b1);
			chk(mem[m ? 24'h000300 : 24'h000200], 8'h33);
		end
		wr(OFS_CONFIG_REG3_VOLATILE, 32'h0);
		wen();
		send('{OPC_PAGE_PROGRAM_4BYTE_CMD, 8'h00, 8'h00, 8'h30, 8'h00, 8'hC3}, 0);
		run(1'b1);
		chk(mem[24'h003000], 8'hC3);
		// Host keeps to aligned 16-byte blocks, the recommended program unit
		for (int i = 0; i < 16; i++) blk16.push_back(8'(i));
		pgm(24'h000410, blk16, 1'b1);
		chk(npgm, 16);
		chk(mem[24'h00041F], 8'h0F);
		// Quad lines with the four-byte address selected
		wr(OFS_CONFIG_REG2_VOLATILE, 32'hC0);
		qm = 1'b1;
		wen();
		send('{OPC_PAGE_PROGRAM_CMD, 8'h00, 8'h00, 8'h20, 8'h00, 8'h0F}, 0);
		run(1'b1);
		chk(mem[24'h002000], 8'h0F);
		qm = 1'b0;
		wr(OFS_CONFIG_REG2_VOLATILE, 32'h0);
		ers(OPC_UNIFORM_WIPE_CMD, 32'h0, 32'h010000, 1, 0, 24'h0, 19'h0);
		// Select rises before the last address byte: nothing runs, latch is dropped
		wen();
		send('{OPC_UNIFORM_WIPE_CMD, 8'h01, 8'h00}, 0);
		run(1'b0);
		chk(nwipe, 0);
		rd(OFS_STATUS_REG1_VOLATILE, 32'h0);
		ers(OPC_UNIFORM_WIPE_CMD, 32'h0, 32'h010000, 0, 1, 24'h010000, 19'h10000);
		ers(OPC_UNIFORM_WIPE_4BYTE_CMD, 32'h2, 32'h040000, 0, 1, 24'h040000, 19'h40000);
		ers(OPC_UNIFORM_WIPE_CMD, 32'h0, 32'h0, 0, 1, 24'h008000, 19'h08000);
		ers(OPC_SMALL_WIPE_CMD, 32'h0, 32'h001000, 0, 1, 24'h001000, 19'h01000);
		ers(OPC_SMALL_WIPE_4BYTE_CMD, 32'h0, 32'h7000, 0, 1, 24'h007000, 19'h01000);
		ers(OPC_SMALL_WIPE_CMD, 32'h0, 32'h100000, 0, 0, 24'h0, 19'h0);
		rd(OFS_STATUS_REG1_VOLATILE, 32'h0);
		ers(OPC_SMALL_WIPE_CMD, 32'h8, 32'h001000, 0, 0, 24'h0, 19'h0);
		rd(OFS_STATUS_REG1_VOLATILE, 32'h2);
		// Top four uniform sectors locked by the block bits
		wr(OFS_STATUS_REG1_VOLATILE, 32'h4);
		ers(OPC_UNIFORM_WIPE_CMD, 32'h0, 32'hFD0000, 0, 0, 24'h0, 19'h0);
		rd(OFS_STATUS_REG1_VOLATILE, 32'h24);
		wr(OFS_STATUS_REG1_VOLATILE, 32'h24);
		ers(OPC_SMALL_WIPE_CMD, 32'h4, 32'hFFF000, 0, 0, 24'h0, 19'h0);
		rd(OFS_STATUS_REG1_VOLATILE, 32'h24);
		pgm(24'hFF0000, '{8'h5A}, 1'bx);
		chk(npgm, 0);
		rd(OFS_STATUS_REG1_VOLATILE, 32'h64);
		wr(OFS_STATUS_REG1_VOLATILE, 32'h60);
		wr(OFS_DYNAMIC_PROTECT_BIT, 32'h1);
		ers(OPC_UNIFORM_WIPE_CMD, 32'h2, 32'h040000, 0, 0, 24'h0, 19'h0);
		rd(OFS_STATUS_REG1_VOLATILE, 32'h20);
		conclude();
	end
endmodule
`default_nettype wire
